/* File: verilog/dual_port_parallel_io.v */
// Top of the dual port parallel I/O block: APB registers, port routing and interrupt chain
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.vh"
module dual_port_parallel_io (
  input  wire        clk_sys_i,
  input  wire        rstn_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire [7:0]  pa_i,
  output wire [7:0]  pa_o,
  output wire [7:0]  pa_oe_o,
  input  wire [7:0]  pb_i,
  output wire [7:0]  pb_o,
  output wire [7:0]  pb_oe_o,
  input  wire        first_port_strobe_n_i,
  input  wire        second_port_strobe_n_i,
  output reg         first_port_ready_o,
  output reg         second_port_ready_o,
  input  wire        chain_enable_in_i,
  output reg         chain_enable_out_o,
  output reg         int_req_n_o,
  input  wire        int_ack_i,
  input  wire        int_done_i,
  output reg  [7:0]  vector_o
);
  // ****************************************
  // Reset release
  // ****************************************
  reg        rst_meta;
  reg        rst_n;

  // Two stage release of the asynchronous reset
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  reg  [1:0] mode_a_reg;
  reg  [1:0] mode_b_reg;
  reg  [2:0] cfg_a_reg;
  reg  [2:0] cfg_b_reg;
  reg  [7:0] mask_a_reg;
  reg  [7:0] mask_b_reg;
  reg        mwait_a_reg;
  reg        mwait_b_reg;
  reg  [7:0] dir_a_reg;
  reg  [7:0] dir_b_reg;
  reg  [7:0] vec_a_reg;
  reg  [7:0] vec_b_reg;
  reg        pend_a_reg;
  reg        pend_b_reg;
  reg        serv_a_reg;
  reg        serv_b_reg;

  wire       setup   = psel_i & ~penable_i;
  wire       access  = psel_i & penable_i;
  wire       wr      = access & pwrite_i;
  wire       rd      = access & ~pwrite_i;
  wire [7:0] wbyte   = pwdata_i[7:0];

  // Address decode shared by the write and read strobes
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'h0) & (addr <= `OFS_STATUS);
    end
  endfunction

  wire wr_data_a = wr & hit(paddr_i, `OFS_DATA_A);
  wire wr_data_b = wr & hit(paddr_i, `OFS_DATA_B);
  wire rd_data_a = rd & hit(paddr_i, `OFS_DATA_A);
  wire rd_data_b = rd & hit(paddr_i, `OFS_DATA_B);
  wire wr_ctrl_a = wr & hit(paddr_i, `OFS_CTRL_A);
  wire wr_ctrl_b = wr & hit(paddr_i, `OFS_CTRL_B);

  // Mode falls back from bidirectional on the second port
  function [1:0] legal_mode;
    input [1:0] m;
    input       second;
    begin
      legal_mode = (second && m == `MODE_BIDIR) ? mode_b_reg : m;
    end
  endfunction

  // Control words, mask follow-up, direction and vectors
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_a_reg  <= `RST_MODE;
      mode_b_reg  <= `RST_MODE;
      cfg_a_reg   <= 3'h0;
      cfg_b_reg   <= 3'h0;
      mask_a_reg  <= `RST_MASK;
      mask_b_reg  <= `RST_MASK;
      mwait_a_reg <= 1'b0;
      mwait_b_reg <= 1'b0;
      dir_a_reg   <= `RST_BYTE;
      dir_b_reg   <= `RST_BYTE;
      vec_a_reg   <= `RST_BYTE;
      vec_b_reg   <= `RST_BYTE;
    end else begin
      if (wr_ctrl_a) begin
        if (mwait_a_reg) begin
          mask_a_reg  <= wbyte;
          mwait_a_reg <= 1'b0;
        end else begin
          mode_a_reg  <= wbyte[`CTRL_MODE_HI:`CTRL_MODE_LO];
          cfg_a_reg   <= wbyte[`CTRL_AND:`CTRL_INT_EN];
          mwait_a_reg <= wbyte[`CTRL_MASK_FL];
        end
      end
      if (wr_ctrl_b) begin
        if (mwait_b_reg) begin
          mask_b_reg  <= wbyte;
          mwait_b_reg <= 1'b0;
        end else begin
          mode_b_reg  <= legal_mode(wbyte[`CTRL_MODE_HI:`CTRL_MODE_LO], 1'b1);
          cfg_b_reg   <= wbyte[`CTRL_AND:`CTRL_INT_EN];
          mwait_b_reg <= wbyte[`CTRL_MASK_FL];
        end
      end
      if (wr & hit(paddr_i, `OFS_DIR_A))
        dir_a_reg <= wbyte;
      if (wr & hit(paddr_i, `OFS_DIR_B))
        dir_b_reg <= wbyte;
      if (wr & hit(paddr_i, `OFS_VEC_A))
        vec_a_reg <= wbyte;
      if (wr & hit(paddr_i, `OFS_VEC_B))
        vec_b_reg <= wbyte;
    end
  end

  // ****************************************
  // Ports
  // ****************************************
  wire       bidir = (mode_a_reg == `MODE_BIDIR);
  wire [7:0] in_a;
  wire [7:0] in_b;
  wire       ordy_a;
  wire       irdy_a;
  wire       oev_a;
  wire       iev_a;
  wire       bev_a;
  wire       ordy_b;
  wire       irdy_b;
  wire       oev_b;
  wire       iev_b;
  wire       bev_b;

  port_unit u_port_a (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n),
    .mode_i      (mode_a_reg),
    .act_hi_i    (cfg_a_reg[1]),
    .and_fn_i    (cfg_a_reg[2]),
    .mask_i      (mask_a_reg),
    .dir_i       (dir_a_reg),
    .wr_i        (wr_data_a),
    .wr_data_i   (wbyte),
    .rd_i        (rd_data_a),
    .pins_i      (pa_i),
    .out_stb_n_i (first_port_strobe_n_i),
    .in_stb_n_i  (bidir ? second_port_strobe_n_i : first_port_strobe_n_i),
    .out_o       (pa_o),
    .oe_o        (pa_oe_o),
    .in_o        (in_a),
    .out_ready_o (ordy_a),
    .in_ready_o  (irdy_a),
    .out_event_o (oev_a),
    .in_event_o  (iev_a),
    .bit_event_o (bev_a)
  );

  port_unit u_port_b (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n),
    .mode_i      (mode_b_reg),
    .act_hi_i    (cfg_b_reg[1]),
    .and_fn_i    (cfg_b_reg[2]),
    .mask_i      (mask_b_reg),
    .dir_i       (dir_b_reg),
    .wr_i        (wr_data_b),
    .wr_data_i   (wbyte),
    .rd_i        (rd_data_b),
    .pins_i      (pb_i),
    .out_stb_n_i (second_port_strobe_n_i),
    .in_stb_n_i  (second_port_strobe_n_i),
    .out_o       (pb_o),
    .oe_o        (pb_oe_o),
    .in_o        (in_b),
    .out_ready_o (ordy_b),
    .in_ready_o  (irdy_b),
    .out_event_o (oev_b),
    .in_event_o  (iev_b),
    .bit_event_o (bev_b)
  );

  // Ready pins; bidirectional input side borrows the second ready
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      first_port_ready_o  <= 1'b0;
      second_port_ready_o <= 1'b0;
    end else begin
      first_port_ready_o  <= ordy_a | (irdy_a & ~bidir);
      second_port_ready_o <= bidir ? irdy_a : (ordy_b | irdy_b);
    end
  end

  // ****************************************
  // Interrupt events and daisy chain
  // ****************************************
  wire ev_a  = cfg_a_reg[0] & (oev_a | (iev_a & ~bidir) | bev_a);
  wire ev_b  = cfg_b_reg[0] & (bidir ? iev_a : (oev_b | iev_b | bev_b));
  wire busy_a = pend_a_reg | serv_a_reg;
  wire busy_b = pend_b_reg | serv_b_reg;
  wire req_a = chain_enable_in_i & pend_a_reg & ~serv_a_reg;
  wire req_b = chain_enable_in_i & ~busy_a & pend_b_reg & ~serv_b_reg;
  wire ack_a = int_ack_i & req_a;
  wire ack_b = int_ack_i & req_b & ~req_a;

  // Pending and in-service state; a new event beats a same cycle acknowledge
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_a_reg <= 1'b0;
      pend_b_reg <= 1'b0;
      serv_a_reg <= 1'b0;
      serv_b_reg <= 1'b0;
      vector_o   <= `RST_BYTE;
    end else begin
      pend_a_reg <= ev_a | (pend_a_reg & ~ack_a);
      pend_b_reg <= ev_b | (pend_b_reg & ~ack_b);
      if (ack_a)
        serv_a_reg <= 1'b1;
      else if (int_done_i & serv_a_reg)
        serv_a_reg <= 1'b0;
      if (ack_b)
        serv_b_reg <= 1'b1;
      else if (int_done_i & ~serv_a_reg & serv_b_reg)
        serv_b_reg <= 1'b0; // End of service goes to the highest port in service
      if (ack_a)
        vector_o <= vec_a_reg & `VEC_LSB_MASK;
      else if (ack_b)
        vector_o <= vec_b_reg & `VEC_LSB_MASK;
    end
  end

  // Chain outputs registered
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      chain_enable_out_o <= 1'b0;
      int_req_n_o        <= 1'b1;
    end else begin
      chain_enable_out_o <= chain_enable_in_i & ~busy_a & ~busy_b;
      int_req_n_o        <= ~(req_a | req_b);
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  reg [7:0] rmux;

  // Read mux
  always @* begin
    case (paddr_i)
      `OFS_DATA_A: rmux = in_a;
      `OFS_DATA_B: rmux = in_b;
      `OFS_CTRL_A: rmux = {2'h0, mwait_a_reg, cfg_a_reg, mode_a_reg};
      `OFS_CTRL_B: rmux = {2'h0, mwait_b_reg, cfg_b_reg, mode_b_reg};
      `OFS_DIR_A:  rmux = dir_a_reg;
      `OFS_DIR_B:  rmux = dir_b_reg;
      `OFS_VEC_A:  rmux = vec_a_reg;
      `OFS_VEC_B:  rmux = vec_b_reg;
      `OFS_STATUS: rmux = {serv_b_reg, serv_a_reg, pend_b_reg, pend_a_reg,
                           irdy_b, ordy_b, irdy_a, ordy_a};
      default:     rmux = 8'h00;
    endcase
  end

  // Read data and error prepared in setup phase; no wait states
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o  <= 32'h00000000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup;
      if (setup) begin
        prdata_o  <= pwrite_i ? 32'h00000000 : {24'h000000, rmux};
        pslverr_o <= ~mapped(paddr_i);
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/pio_defines.vh */
// Register offsets, field positions and reset values of the dual port parallel I/O block
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_DATA_A   8'h00
`define OFS_DATA_B   8'h04
`define OFS_CTRL_A   8'h08
`define OFS_CTRL_B   8'h0C
`define OFS_DIR_A    8'h10
`define OFS_DIR_B    8'h14
`define OFS_VEC_A    8'h18
`define OFS_VEC_B    8'h1C
`define OFS_STATUS   8'h20
// ****************************************
// Control word fields
// ****************************************
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_INT_EN  2
`define CTRL_ACT_HI  3
`define CTRL_AND     4
`define CTRL_MASK_FL 5
// ****************************************
// Mode codes
// ****************************************
`define MODE_OUT     2'h0
`define MODE_IN      2'h1
`define MODE_BIDIR   2'h2
`define MODE_BIT     2'h3
// ****************************************
// Reset values and vector mask
// ****************************************
`define RST_MODE     2'h1
`define RST_BYTE     8'h00
`define RST_MASK     8'hFF
`define VEC_LSB_MASK 8'hFE
`endif

/* File: verilog/port_unit.v */
// One port: handshake, input latch, bit mode drivers and bit mode interrupt condition
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.vh"
module port_unit (
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire [1:0] mode_i,
  input  wire       act_hi_i,
  input  wire       and_fn_i,
  input  wire [7:0] mask_i,
  input  wire [7:0] dir_i,
  input  wire       wr_i,
  input  wire [7:0] wr_data_i,
  input  wire       rd_i,
  input  wire [7:0] pins_i,
  input  wire       out_stb_n_i,
  input  wire       in_stb_n_i,
  output reg  [7:0] out_o,
  output reg  [7:0] oe_o,
  output reg  [7:0] in_o,
  output reg        out_ready_o,
  output reg        in_ready_o,
  output reg        out_event_o,
  output reg        in_event_o,
  output reg        bit_event_o
);
  reg        out_stb_q;
  reg        in_stb_q;
  reg        cond_q;
  wire       is_out  = (mode_i == `MODE_OUT) | (mode_i == `MODE_BIDIR);
  wire       is_in   = (mode_i == `MODE_IN) | (mode_i == `MODE_BIDIR);
  wire       is_bit  = (mode_i == `MODE_BIT);
  wire       out_ack = is_out & ~out_stb_q & out_stb_n_i;
  wire       in_done = is_in & ~in_stb_q & in_stb_n_i;
  wire [7:0] active  = act_hi_i ? pins_i : ~pins_i;
  wire [7:0] live    = ~mask_i & ~dir_i;
  // AND needs every unmasked input active, OR needs any one; fully masked never fires
  wire       cond    = is_bit & (|live) & (and_fn_i ? &(active | ~live) : |(active & live));

  // Strobe history for edge detection
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_stb_q <= 1'b1;
      in_stb_q  <= 1'b1;
      cond_q    <= 1'b0;
    end else begin
      out_stb_q <= out_stb_n_i;
      in_stb_q  <= in_stb_n_i;
      cond_q    <= cond;
    end
  end

  // Output side: data, ready and acknowledge event
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_o       <= `RST_BYTE;
      out_ready_o <= 1'b0;
      out_event_o <= 1'b0;
    end else begin
      if (wr_i)
        out_o <= wr_data_i;
      if (wr_i & is_out)
        out_ready_o <= 1'b1;
      else if (out_ack | ~is_out)
        out_ready_o <= 1'b0;
      out_event_o <= out_ack;
    end
  end

  // Input side: latch while strobe low, ready from CPU reads
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_o        <= `RST_BYTE;
      in_ready_o  <= 1'b0;
      in_event_o  <= 1'b0;
      bit_event_o <= 1'b0;
    end else begin
      if (is_bit)
        in_o <= (pins_i & ~dir_i) | (out_o & dir_i);
      else if (is_in & ~in_stb_n_i)
        in_o <= pins_i;
      if (in_done | ~is_in)
        in_ready_o <= 1'b0;
      else if (rd_i)
        in_ready_o <= 1'b1;
      in_event_o  <= in_done;
      bit_event_o <= cond & ~cond_q;
    end
  end

  // Driver enables per mode
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_o <= 8'h00;
    end else begin
      case (mode_i)
        `MODE_OUT:   oe_o <= 8'hFF;
        `MODE_IN:    oe_o <= 8'h00;
        `MODE_BIDIR: oe_o <= out_stb_n_i ? 8'h00 : 8'hFF;
        `MODE_BIT:   oe_o <= dir_i;
        default:     oe_o <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: testbench/pio_checker.sv */
// Assertion checker for the dual port parallel I/O block
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.vh"
module pio_checker (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [7:0]  pa_oe_o,
  input wire logic        first_port_strobe_n_i,
  input wire logic        first_port_ready_o,
  input wire logic        chain_enable_in_i,
  input wire logic        chain_enable_out_o,
  input wire logic        int_req_n_o,
  input wire logic [7:0]  vector_o
);
  // ********
  // Mode tracking of the first port
  // ********
  logic [1:0] mode_reg;
  logic       wait_reg;
  wire        acc = psel_i && penable_i;
  // Follows control writes, a mask word leaves the mode alone
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_reg <= `RST_MODE;
      wait_reg <= 1'b0;
    end else if (acc && pwrite_i && paddr_i == `OFS_CTRL_A) begin
      mode_reg <= wait_reg ? mode_reg : pwdata_i[1:0];
      wait_reg <= !wait_reg && pwdata_i[5];
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // ********
  // Assertions
  // ********
  a_zero_wait: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing in access cycle");
  a_err_unmapped: assert property (acc && (paddr_i[1:0] != 2'h0 || paddr_i > `OFS_STATUS) |-> pslverr_o)
    else $error("unmapped access without error");
  a_bit_ready_low: assert property ((mode_reg == `MODE_BIT) [*4] |-> !first_port_ready_o)
    else $error("ready high in bit mode");
  a_out_ready: assert property (acc && pwrite_i && paddr_i == `OFS_DATA_A && mode_reg == `MODE_OUT
    |-> ##[1:3] first_port_ready_o)
    else $error("no ready after output write");
  a_in_ready: assert property (acc && !pwrite_i && paddr_i == `OFS_DATA_A && mode_reg == `MODE_IN
    |-> ##[1:3] first_port_ready_o)
    else $error("no ready after input read");
  a_bidir_oe: assert property (mode_reg == `MODE_BIDIR && $past(mode_reg) == `MODE_BIDIR
    && first_port_strobe_n_i == $past(first_port_strobe_n_i) |-> pa_oe_o == {8{!first_port_strobe_n_i}})
    else $error("bidirectional drive not gated by strobe");
  a_vec_even: assert property (!vector_o[0])
    else $error("vector bit zero set");
  a_chain_block: assert property (!chain_enable_in_i |=> !chain_enable_out_o)
    else $error("chain out passed while chain in low");
  a_req_chain: assert property (!int_req_n_o |-> $past(chain_enable_in_i))
    else $error("request while chain in low");
  c_err: cover property (acc && pslverr_o);
  c_bidir: cover property (mode_reg == `MODE_BIDIR && pa_oe_o == 8'hFF);
  c_bit_int: cover property (mode_reg == `MODE_BIT && !int_req_n_o);
endmodule
bind dual_port_parallel_io pio_checker u_chk (.clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .pa_oe_o, .first_port_strobe_n_i, .first_port_ready_o,
  .chain_enable_in_i, .chain_enable_out_o, .int_req_n_o, .vector_o);
`default_nettype wire

/* File: testbench/pio_peer.sv */
// Peripheral model for one ready/strobe port
`timescale 1ns/1ps
`default_nettype none
module pio_peer (
  input  wire logic       clk_sys_i,
  input  wire logic       ready_i,
  input  wire logic [1:0] role_i,
  input  wire logic [7:0] lvl_i,
  input  wire logic [7:0] give_i,
  input  wire logic [2:0] dly_i,
  output var  logic       stb_n_o,
  output var  logic [7:0] drv_o,
  output var  logic [7:0] got_o,
  output var  logic [7:0] cnt_o
);
  // Role 0 idle, 1 takes bytes, 2 gives bytes, 3 holds static levels
  initial begin
    stb_n_o = 1'b1;
    drv_o = 8'h00;
    got_o = 8'h00;
    cnt_o = 8'h00;
    forever begin
      @(posedge clk_sys_i);
      if (role_i == 2'h3) begin
        drv_o <= give_i;
      end else if (role_i != 2'h0 && ready_i) begin
        repeat (dly_i) @(posedge clk_sys_i);
        if (role_i == 2'h2) drv_o <= give_i;
        stb_n_o <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        got_o <= lvl_i;
        stb_n_o <= 1'b1;
        cnt_o <= cnt_o + 8'h01;
        repeat (4) @(posedge clk_sys_i);
        drv_o <= ~drv_o; // Released lines no longer show the byte
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/dual_port_parallel_io_tb.sv */
// Self-checking testbench of the dual port parallel I/O block
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.vh"
module dual_port_parallel_io_tb;
  logic        clk, rstn, psel, penable, pwrite, chain_in, int_ack, int_done, pslverr, pready;
  logic        rdy_a, rdy_b, stb_a, stb_b, chain_out, int_req_n, rerr;
  logic [7:0]  paddr, pa_o, pa_oe, pb_o, pb_oe, vector, give_a, give_b, drv_a, drv_b;
  logic [7:0]  got_a, got_b, cnt_a, cnt_b, lv, mk;
  logic [1:0]  role_a, role_b;
  logic [2:0]  dly;
  logic [31:0] pwdata, prdata, rdat, seed;
  int          n_errors, cmp_count, k, c, j;
  wire  [7:0]  pa_lvl = (pa_oe & pa_o) | (~pa_oe & drv_a);
  wire  [7:0]  pb_lvl = (pb_oe & pb_o) | (~pb_oe & drv_b);
  dual_port_parallel_io u_dut (.clk_sys_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pa_i(pa_lvl), .pa_o(pa_o), .pa_oe_o(pa_oe), .pb_i(pb_lvl), .pb_o(pb_o),
    .pb_oe_o(pb_oe), .first_port_strobe_n_i(stb_a), .second_port_strobe_n_i(stb_b),
    .first_port_ready_o(rdy_a), .second_port_ready_o(rdy_b), .chain_enable_in_i(chain_in),
    .chain_enable_out_o(chain_out), .int_req_n_o(int_req_n), .int_ack_i(int_ack),
    .int_done_i(int_done), .vector_o(vector));
  pio_peer u_pa (.clk_sys_i(clk), .ready_i(rdy_a), .role_i(role_a), .lvl_i(pa_lvl), .give_i(give_a),
    .dly_i(dly), .stb_n_o(stb_a), .drv_o(drv_a), .got_o(got_a), .cnt_o(cnt_a));
  pio_peer u_pb (.clk_sys_i(clk), .ready_i(rdy_b), .role_i(role_b), .lvl_i(pb_lvl), .give_i(give_b),
    .dly_i(dly), .stb_n_o(stb_b), .drv_o(drv_b), .got_o(got_b), .cnt_o(cnt_b));
  // ********
  // Helpers
  // ********
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Interrupt expected in bit mode for levels, mask, polarity and function
  function automatic logic exp_int(input logic [7:0] l, input logic [7:0] m, input logic hi, input logic an);
    logic [7:0] act;
    act = (hi ? l : ~l) & ~m;
    return an ? (act == ~m && m != 8'hFF) : (act != 8'h00);
  endfunction
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
    if (i == 20) n_errors++;
    if (i == 20) final_report();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic wait_peer(input logic [7:0] ca, input logic [7:0] cb);
    int i;
    // A count of FF on the first port waits for the interrupt request instead
    for (i = 0; i < 200 && ((ca == 8'hFF) ? (int_req_n !== 1'b0) : (cnt_a !== ca || cnt_b !== cb)); i++) tick(1);
    if (i == 200) n_errors++;
    if (i == 200) final_report();
  endtask
  // Acknowledge, check the vector, end the service
  task automatic serve(input logic [7:0] ev);
    @(posedge clk);
    int_ack <= 1'b1;
    @(posedge clk);
    int_ack <= 1'b0;
    tick(2);
    chk("vector", ev, vector);
    int_done <= 1'b1;
    @(posedge clk);
    int_done <= 1'b0;
    tick(3);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ********
  // Main sequence
  // ********
  initial begin
    {rstn, psel, penable, pwrite, int_ack, int_done, paddr, pwdata, give_a, give_b, dly} = '0;
    {role_a, role_b, n_errors, cmp_count} = '0;
    chain_in = 1'b1;
    seed = 32'hCF6268FF;
    tick(12);
    rstn <= 1'b1;
    tick(3);
    rdc("ctrl a", `OFS_CTRL_A, 32'h1);
    rdc("status", `OFS_STATUS, 32'h0);
    apb(1'b1, 8'h06, 32'h0);
    chk("err", 1'b1, rerr);
    rdc("unmapped", 8'h24, 32'h0);
    for (k = 3; k >= 0; k--) begin
      apb(1'b1, `OFS_CTRL_A, k);
      rdc("mode", `OFS_CTRL_A, k);
    end
    apb(1'b1, `OFS_CTRL_B, {30'h0, `MODE_BIDIR});
    rdc("ctrl b", `OFS_CTRL_B, 32'h1);
    role_a <= 2'h1;
    for (k = 0; k < 6; k++) begin
      seed = xs(seed);
      dly <= seed[10:8];
      apb(1'b1, `OFS_DATA_A, {24'h0, seed[7:0]});
      wait_peer(k + 1, 0);
      chk("taken a", seed[7:0], got_a);
    end
    apb(1'b1, `OFS_VEC_A, 32'h5B);
    apb(1'b1, `OFS_VEC_B, 32'h37);
    apb(1'b1, `OFS_CTRL_A, 32'h04);
    apb(1'b1, `OFS_CTRL_B, 32'h04);
    role_b <= 2'h1;
    apb(1'b1, `OFS_DATA_B, 32'hC3);
    apb(1'b1, `OFS_DATA_A, 32'h3C);
    wait_peer(7, 1);
    chk("taken b", 8'hC3, got_b);
    wait_peer(8'hFF, 1);
    chk("chain out", 1'b0, chain_out);
    chain_in <= 1'b0;
    tick(3);
    chk("req gated", 1'b1, int_req_n);
    chain_in <= 1'b1;
    tick(3);
    serve(8'h5A);
    serve(8'h36);
    chk("req idle", 1'b1, int_req_n);
    chk("chain idle", 1'b1, chain_out);
    apb(1'b1, `OFS_CTRL_A, {30'h0, `MODE_IN});
    role_a <= 2'h2;
    seed = xs(seed);
    give_a <= seed[7:0];
    apb(1'b0, `OFS_DATA_A, 32'h0);
    wait_peer(8, 1);
    role_a <= 2'h0;
    tick(3);
    chk("ready a", 1'b0, rdy_a);
    rdc("in a", `OFS_DATA_A, {24'h0, seed[7:0]});
    role_a <= 2'h3;
    for (c = 0; c < 4; c++) begin
      seed = xs(seed);
      mk = (c == 3) ? 8'hFF : seed[15:8];
      apb(1'b1, `OFS_CTRL_A, 32'h23 | (c << 3));
      // Idle levels only once the new polarity stands with interrupts off
      give_a <= {8{!c[0]}};
      apb(1'b1, `OFS_CTRL_A, {24'h0, mk});
      apb(1'b1, `OFS_CTRL_A, 32'h07 | (c << 3));
      for (j = 0; j < 4; j++) begin
        seed = xs(seed);
        lv = (j == 0) ? {8{c[0]}} : seed[7:0];
        give_a <= {8{!c[0]}};
        tick(4);
        give_a <= lv;
        tick(8);
        chk("bit int", !exp_int(lv, mk, c[0], c[1]), int_req_n);
        if (int_req_n === 1'b0) serve(8'h5A);
      end
    end
    apb(1'b1, `OFS_DIR_A, 32'hA5);
    apb(1'b1, `OFS_DATA_A, 32'h3C);
    tick(2);
    chk("oe a", 8'hA5, pa_oe);
    chk("out a", 8'h24, pa_o & 8'hA5);
    chk("bit ready", 1'b0, rdy_a);
    apb(1'b1, `OFS_CTRL_B, 32'h23);
    apb(1'b1, `OFS_CTRL_B, 32'hFF);
    apb(1'b1, `OFS_CTRL_A, {30'h0, `MODE_BIDIR});
    role_a <= 2'h1;
    seed = xs(seed);
    apb(1'b1, `OFS_DATA_A, {24'h0, seed[7:0]});
    wait_peer(9, 1);
    chk("bidir a", seed[7:0], got_a);
    tick(2);
    chk("bidir float", 8'h00, pa_oe);
    chk("oe b", 8'h00, pb_oe);
    final_report();
  end
endmodule
`default_nettype wire
